// [core/aso_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"

module aso_top (
    input wire clk,
    input wire rst_n,
    input wire [`ASO_DATA_W-1:0] sample_code,
    input wire output_format_select,
    input wire sleep_request,
    output wire [`ASO_DATA_W-1:0] data_out,
    output wire data_out_oe,
    output wire data_valid,
    output wire powered_down
);
    localparam ST_RUN = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_WAKE = 2'h2;

    // load values cut to the counter widths
    localparam [31:0] WAKE_FULL = `ASO_WAKE_CYC;
    localparam [31:0] SETTLE_FULL = `ASO_FMT_SETTLE;
    localparam [7:0] WAKE_LOAD = WAKE_FULL[7:0];
    localparam [3:0] SETTLE_LOAD = SETTLE_FULL[3:0];

    reg [1:0] rst_sync_r;
    wire rst_int_n;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] wake_cnt_r;
    reg [7:0] wake_cnt_nxt;
    wire wake_last;
    wire in_sleep_state;

    reg fmt_prev_r;
    reg fmt_prev_nxt;
    reg [3:0] fmt_cnt_r;
    reg [3:0] fmt_cnt_nxt;
    wire fmt_changed;
    wire fmt_settled;

    wire pipe_flush;
    wire [`ASO_DATA_W-1:0] pipe_word;
    wire pipe_ok;

    reg [`ASO_DATA_W-1:0] word_r;
    reg [`ASO_DATA_W-1:0] word_nxt;
    reg word_ok_r;
    reg word_ok_nxt;
    wire asleep_now;

    function [`ASO_DATA_W-1:0] fmt_code;
        input [`ASO_DATA_W-1:0] raw;
        input twos;
        begin
            fmt_code = {raw[`ASO_MSB] ^ twos, raw[`ASO_MSB-1:0]};
        end
    endfunction

    // outputs are parked while asleep or about to sleep
    function outputs_parked;
        input [1:0] st;
        input req;
        begin
            outputs_parked = req || st == ST_SLEEP;
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_int_n = rst_sync_r[1];
    assign in_sleep_state = state_r == ST_SLEEP;
    assign wake_last = wake_cnt_r <= 8'h01;

    // a sleep request wins from every state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_request) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleep_request) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (sleep_request) begin
                    state_nxt = ST_SLEEP;
                end else if (wake_last) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_SLEEP;
            end
        endcase
    end

    // recovery count, reloaded for as long as the block sleeps
    always @* begin
        wake_cnt_nxt = wake_cnt_r;
        case (state_r)
            ST_SLEEP: begin
                wake_cnt_nxt = WAKE_LOAD;
            end
            ST_WAKE: begin
                if (wake_last) begin
                    wake_cnt_nxt = 8'h00;
                end else begin
                    wake_cnt_nxt = wake_cnt_r - 8'h01;
                end
            end
            default: begin
                wake_cnt_nxt = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_r <= ST_SLEEP;
            wake_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    assign fmt_changed = fmt_prev_r != output_format_select;
    assign fmt_settled = !fmt_changed && fmt_cnt_r == 4'h0;

    // a new change restarts the settle count
    always @* begin
        fmt_prev_nxt = output_format_select;
        fmt_cnt_nxt = fmt_cnt_r;
        if (fmt_changed) begin
            fmt_cnt_nxt = SETTLE_LOAD;
        end else if (fmt_cnt_r != 4'h0) begin
            fmt_cnt_nxt = fmt_cnt_r - 4'h1;
        end
    end

    always @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            fmt_prev_r <= 1'b0;
            fmt_cnt_r <= 4'h0;
        end else begin
            fmt_prev_r <= fmt_prev_nxt;
            fmt_cnt_r <= fmt_cnt_nxt;
        end
    end

    assign pipe_flush = in_sleep_state;

    // acquisition stage, five more stages, then the output register
    aso_pipe u_pipe (
        .clk(clk),
        .rst_n(rst_int_n),
        .flush(pipe_flush),
        .din(sample_code),
        .dout(pipe_word),
        .dout_ok(pipe_ok)
    );

    assign asleep_now = outputs_parked(state_r, sleep_request);

    always @* begin
        word_nxt = `ASO_UNDEF_WORD;
        word_ok_nxt = 1'b0;
        if (asleep_now) begin
            word_nxt = `ASO_UNDEF_WORD;
            word_ok_nxt = 1'b0;
        end else begin
            word_nxt = fmt_code(pipe_word, output_format_select);
            word_ok_nxt = pipe_ok && state_r == ST_RUN &&
                fmt_settled;
        end
    end

    always @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            word_r <= `ASO_UNDEF_WORD;
            word_ok_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            word_ok_r <= word_ok_nxt;
        end
    end

    assign data_out = word_r;
    assign data_out_oe = !asleep_now;
    assign data_valid = word_ok_r;
    assign powered_down = in_sleep_state;
endmodule

`default_nettype wire

// [core/aso_defs.vh]
`ifndef ASO_DEFS_VH
`define ASO_DEFS_VH

`define ASO_DATA_W 12
`define ASO_PIPE_LAT 6
`define ASO_MSB 11
`define ASO_FMT_SETTLE 3
`define ASO_WAKE_NS 1000
`define ASO_CLK_NS 20
`define ASO_WAKE_CYC ((`ASO_WAKE_NS + `ASO_CLK_NS - 1) / `ASO_CLK_NS)
`define ASO_UNDEF_WORD 12'h000

`endif

// [core/aso_pipe.v]
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"

module aso_pipe (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire [`ASO_DATA_W-1:0] din,
    output wire [`ASO_DATA_W-1:0] dout,
    output wire dout_ok
);
    reg [`ASO_DATA_W-1:0] stage_r [0:`ASO_PIPE_LAT-1];
    reg [`ASO_PIPE_LAT-1:0] ok_r;
    integer i;

    // six-stage delay, one word per clock
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `ASO_PIPE_LAT; i = i + 1) begin
                stage_r[i] <= 12'h000;
            end
            ok_r <= 6'h00;
        end else begin
            stage_r[0] <= din;
            ok_r <= flush ? 6'h00 : {ok_r[`ASO_PIPE_LAT-2:0], 1'b1};
            for (i = 1; i < `ASO_PIPE_LAT; i = i + 1) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign dout = stage_r[`ASO_PIPE_LAT-1];
    assign dout_ok = ok_r[`ASO_PIPE_LAT-1];
endmodule

`default_nettype wire

// [tb/aso_chk.sv]
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"
module aso_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] sample_code,
    input wire logic output_format_select,
    input wire logic sleep_request,
    input wire logic [11:0] data_out,
    input wire logic data_out_oe,
    input wire logic data_valid,
    input wire logic powered_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    lat_fmt_a: assert property (data_valid &&
        output_format_select == $past(output_format_select, 7) |->
        data_out == {$past(sample_code[11] ^ output_format_select, 7),
        $past(sample_code[10:0], 7)}) else $error("word wrong");
    oe_off_a: assert property (sleep_request |-> !data_out_oe)
        else $error("oe in sleep");
    oe_on_a: assert property (!sleep_request && !powered_down
        |-> data_out_oe) else $error("oe missing");
    sleep_hold_a: assert property (sleep_request |=> powered_down)
        else $error("not asleep");
    sleep_out_a: assert property (powered_down && $past(powered_down)
        |-> !data_valid && data_out == `ASO_UNDEF_WORD)
        else $error("sleep out");
    wake_a: assert property ($fell(sleep_request) |-> !data_valid[*8])
        else $error("early valid");
    fmt_chg_a: assert property ($changed(output_format_select)
        |=> !data_valid[*3]) else $error("format not flagged");
    word_rate_a: assert property (data_valid && !sleep_request &&
        $stable(output_format_select) |=> data_valid) else $error("gap");
    cover property ($fell(powered_down));
    cover property (data_valid && output_format_select);
    cover property ($changed(output_format_select) && data_valid);
endmodule
bind aso_top aso_chk chk_u (.*);
`default_nettype wire

// [tb/aso_cap.sv]
`timescale 1ns/1ns
`default_nettype none
module aso_cap (
    input wire logic clk,
    input wire logic [11:0] d,
    input wire logic ok,
    output logic [11:0] q
);
    // latch on the same rising edge that clocks the converter
    always @(posedge clk) begin
        if (ok) q <= d;
    end
endmodule
`default_nettype wire

// [tb/tb_aso_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "aso_defs.vh"
module tb_aso_top;
    logic clk = 0, rst_n = 0, fs = 0, sl = 0;
    logic [11:0] sc = 12'h000;
    logic [11:0] cv [4] = '{12'h000, 12'h800, 12'hFFF, 12'h5A3};
    wire [11:0] dout, cq;
    wire oe, vld, pd;
    int n_mismatch = 0, checks = 0, cyc = 0;
    always #10 clk = ~clk;
    aso_top dut_u (.clk(clk), .rst_n(rst_n), .sample_code(sc),
        .output_format_select(fs), .sleep_request(sl), .data_out(dout),
        .data_out_oe(oe), .data_valid(vld), .powered_down(pd));
    aso_cap cap_u (.clk(clk), .d(dout), .ok(vld), .q(cq));
    task chk(input string nm, input logic [11:0] s, e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            summarize;
        end
    end
    task wv(output int n);
        n = 0;
        while (n < 200 && vld !== 1'b1) begin
            @(negedge clk);
            n++;
        end
    endtask
    task t_run(input logic f);
        int w;
        fs = f;
        foreach (cv[k]) begin
            sc = cv[k];
            repeat (12) @(negedge clk);
            wv(w);
            @(negedge clk);
            chk("word", cq, {cv[k][11] ^ f, cv[k][10:0]});
            chk("dout", dout, {cv[k][11] ^ f, cv[k][10:0]});
        end
        $display("run test done fmt %0d", f);
    endtask
    task t_sleep;
        int w;
        logic lo, hi;
        sl = 1;
        repeat (4) @(negedge clk);
        chk("sleep", {8'h0, oe, vld, pd, 1'b0}, 12'h002);
        chk("dout", dout, `ASO_UNDEF_WORD);
        sl = 0;
        repeat (4) @(negedge clk);
        chk("wake", {11'h0, vld}, 12'h000);
        wv(w);
        chk("back", {11'h0, vld}, 12'h001);
        lo = w + 4 >= `ASO_WAKE_CYC;
        hi = w + 4 <= `ASO_WAKE_CYC + `ASO_PIPE_LAT + 2;
        chk("wake time", {10'h0, lo, hi}, 12'h003);
        $display("sleep test done");
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        t_run(0);
        t_run(1);
        t_sleep;
        t_run(0);
        summarize;
    end
endmodule
`default_nettype wire
